// [rtl/hwloop_ctrl.sv]
// hwloop_ctrl.sv: zero-overhead hardware loop controller, top level
// Functional notes
// - first cycle pushes end address and count
// - count operand loads the iteration counter
// - zero count runs body 65536 times
// - short count fills low 12, clears top
// - count operand from indirect address modes
// - second cycle pushes program counter, status word
// - stacked counter is first body address
// - end address register gets expression minus one
// - third cycle sets flag, compare fetches
// - match, count not one: decrement, branch back
// - branch target copied, stack not popped
// - match, count one: begin end processing
// - restore flag, pop, restore registers, pop
// - body refetched every pass
// - exit restores only the loop flag of the status word
// - reset clears the loop flag
// - loop flag is status bit 15
// - afterwards fetch continues past loop body
// assumes the fetch sequencer presents fetch addresses through the register
// bus and takes the next address back; the count operand is already read.
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`include "hwloop_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module hwloop_ctrl
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // axi4-lite write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import hwloop_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // bus front end

  logic wrStb;
  logic [11:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrOk;
  logic [11:0] rdAddr;
  logic [31:0] rdData;
  logic rdOk;

  hwloop_axil u_axil (
    .clk(clk),
    .rstn(rstn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wrStb(wrStb),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrOk(wrOk),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdOk(rdOk)
  );

  // register decode used for writes; reads decode in the case below
  function automatic logic isReg(input logic [11:0] a, input logic [11:0] off);
    isReg = (a == off);
  endfunction

  // low half-word byte lanes merged into an old value
  function automatic hwloop_word_t merge16(input hwloop_word_t old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // software staging registers

  hwloop_word_t iterArg_r; // count operand for the next loop start
  hwloop_word_t endExpr_r; // end expression for the next loop start
  hwloop_word_t pcNext_r; // address after the loop instruction
  hwloop_word_t fetchAddr_r; // fetch address under test
  logic shortCnt_r; // count is a 12-bit immediate
  logic startReq; // start pulse from software
  logic fetchReq; // fetch pulse from sequencer

  assign startReq = wrStb && isReg(wrAddr, `HWL_OFF_CTRL) && wrStrb[0]
                    && wrData[`HWL_CTRL_START];
  assign fetchReq = wrStb && isReg(wrAddr, `HWL_OFF_FADR) && wrStrb[0];

  // staging writes; the count operand reaches here already fetched through
  // whichever indirect address mode the instruction used
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      iterArg_r <= `HWL_RST_WORD;
      endExpr_r <= `HWL_RST_WORD;
      pcNext_r <= `HWL_RST_WORD;
      fetchAddr_r <= `HWL_RST_WORD;
      shortCnt_r <= 1'b0;
    end
    else if (wrStb)
    begin
      if (isReg(wrAddr, `HWL_OFF_ITER))
        iterArg_r <= merge16(iterArg_r, wrData, wrStrb);
      if (isReg(wrAddr, `HWL_OFF_ENDX))
        endExpr_r <= merge16(endExpr_r, wrData, wrStrb);
      if (isReg(wrAddr, `HWL_OFF_PCNX))
        pcNext_r <= merge16(pcNext_r, wrData, wrStrb);
      if (isReg(wrAddr, `HWL_OFF_FADR))
        fetchAddr_r <= merge16(fetchAddr_r, wrData, wrStrb);
      if (isReg(wrAddr, `HWL_OFF_CTRL) && wrStrb[0])
        shortCnt_r <= wrData[`HWL_CTRL_SHORT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loop state and stack

  hwloop_seq_e seq_r;
  hwloop_word_t loopEndAddr_r; // loop end address
  hwloop_word_t loopIterCount_r; // passes still to run
  hwloop_word_t statusWord_r; // status word, flag at bit 15
  hwloop_word_t programCounter_r; // next fetch address answered
  logic fetchPend_r; // a fetch is being evaluated
  hwloop_stkop_s stkOp;
  logic [`HWL_SP_W-1:0] stackPtr;
  hwloop_entry_s stackTop;
  hwloop_entry_s stackBelow;
  logic loopActiveFlag;
  logic endMatch;
  logic lastPass;

  assign loopActiveFlag = statusWord_r[`HWL_SR_LOOP];
  // exact 16-bit equality, only while the loop flag is set
  assign endMatch = fetchPend_r && loopActiveFlag
                    && (fetchAddr_r == loopEndAddr_r);
  assign lastPass = (loopIterCount_r == 16'h0001);

  hwloop_stack u_stack (
    .clk(clk),
    .rstn(rstn),
    .op(stkOp),
    .stackPtr(stackPtr),
    .top(stackTop),
    .below(stackBelow)
  );

  // stack requests from the start sequence and from loop exit
  always_comb
  begin
    stkOp = '0;
    case (seq_r)
      HWL_PUSH1:
      begin
        stkOp.push = 1'b1;
        stkOp.data = '{high: loopEndAddr_r, low: loopIterCount_r};
      end
      HWL_PUSH2:
      begin
        stkOp.push = 1'b1;
        stkOp.data = '{high: pcNext_r, low: statusWord_r};
      end
      default:
        // first pop on the last match, second pop one cycle later
        stkOp.pop = (endMatch && lastPass) || exitPop2_r;
    endcase
  end

  // start sequence: push, push, arm
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      seq_r <= HWL_IDLE;
    else
      case (seq_r)
        HWL_IDLE: seq_r <= startReq ? HWL_PUSH1 : HWL_IDLE;
        HWL_PUSH1: seq_r <= HWL_PUSH2;
        HWL_PUSH2: seq_r <= HWL_ARM;
        HWL_ARM: seq_r <= HWL_IDLE;
        default: seq_r <= HWL_IDLE;
      endcase
  end

  // fetch evaluation takes one cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      fetchPend_r <= 1'b0;
    else
      fetchPend_r <= fetchReq && (seq_r == HWL_IDLE);
  end

  // second pop of loop exit happens the cycle after the first
  logic exitPop2_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      exitPop2_r <= 1'b0;
    else
      exitPop2_r <= endMatch && lastPass && (seq_r == HWL_IDLE);
  end

  // loop registers: load on start, decrement on pass, restore on exit
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      loopIterCount_r <= `HWL_RST_WORD;
      loopEndAddr_r <= `HWL_RST_WORD;
    end
    else if (seq_r == HWL_PUSH1)
    begin
      // zero is kept as zero: decrementing wraps it to run 65536 passes
      if (shortCnt_r)
        loopIterCount_r <= iterArg_r & `HWL_SHORT_MASK;
      else
        loopIterCount_r <= iterArg_r;
    end
    else if (seq_r == HWL_PUSH2)
      loopEndAddr_r <= endExpr_r - 16'h0001;
    else if (endMatch && !lastPass)
      loopIterCount_r <= loopIterCount_r - 16'h0001;
    else if (exitPop2_r)
    begin
      loopEndAddr_r <= stackTop.high;
      loopIterCount_r <= stackTop.low;
    end
  end

  // status word: loop flag from the start and exit logic, bits 14:0 from software
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      statusWord_r <= `HWL_RST_WORD;
    else
    begin
      if (seq_r == HWL_ARM)
        statusWord_r[`HWL_SR_LOOP] <= 1'b1;
      else if (endMatch && lastPass)
        statusWord_r[`HWL_SR_LOOP] <= stackTop.low[`HWL_SR_LOOP];
      // software bits move apart from the flag, so neither loses to the other
      if (wrStb && isReg(wrAddr, `HWL_OFF_STAT))
        statusWord_r[14:0] <= 15'(merge16(statusWord_r, wrData, wrStrb));
    end
  end

  // next fetch address answered to the sequencer
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      programCounter_r <= `HWL_RST_WORD;
    else if (fetchPend_r)
    begin
      if (endMatch && !lastPass)
        programCounter_r <= stackTop.high;
      else
        programCounter_r <= fetchAddr_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads

  logic busy; // start sequence still running
  assign busy = (seq_r != HWL_IDLE);

  always_comb
  begin
    rdOk = 1'b1;
    rdData = 32'h0000_0000;
    case (rdAddr)
      `HWL_OFF_CTRL: rdData = {29'h0, fetchPend_r, shortCnt_r, busy};
      `HWL_OFF_ITER: rdData = {16'h0000, iterArg_r};
      `HWL_OFF_ENDX: rdData = {16'h0000, endExpr_r};
      `HWL_OFF_LCNT: rdData = {16'h0000, loopIterCount_r};
      `HWL_OFF_LEND: rdData = {16'h0000, loopEndAddr_r};
      `HWL_OFF_STAT: rdData = {16'h0000, statusWord_r};
      `HWL_OFF_SPTR: rdData = {28'h000_0000, stackPtr};
      `HWL_OFF_TOPH: rdData = {16'h0000, stackTop.high};
      `HWL_OFF_TOPL: rdData = {16'h0000, stackTop.low};
      `HWL_OFF_FADR: rdData = {16'h0000, fetchAddr_r};
      `HWL_OFF_PCNX: rdData = {16'h0000, pcNext_r};
      `HWL_OFF_PCUR: rdData = {16'h0000, programCounter_r};
      default: rdOk = 1'b0;
    endcase
  end

  // writes to read-only or unmapped offsets answer with an error
  assign wrOk = isReg(wrAddr, `HWL_OFF_CTRL) || isReg(wrAddr, `HWL_OFF_ITER)
                || isReg(wrAddr, `HWL_OFF_ENDX) || isReg(wrAddr, `HWL_OFF_PCNX)
                || isReg(wrAddr, `HWL_OFF_FADR) || isReg(wrAddr, `HWL_OFF_STAT);

endmodule // hwloop_ctrl

`default_nettype wire

// [rtl/hwloop_consts.svh]
// hwloop_consts.svh: offsets, field positions, reset values, stack sizes and bus responses for the loop unit
// assumes inclusion by its bare name from the loop unit files
`ifndef HWLOOP_CONSTS_SVH
`define HWLOOP_CONSTS_SVH

// register byte offsets on the register bus
`define HWL_OFF_CTRL 12'h000
`define HWL_OFF_ITER 12'h004
`define HWL_OFF_ENDX 12'h008
`define HWL_OFF_LCNT 12'h00C
`define HWL_OFF_LEND 12'h010
`define HWL_OFF_STAT 12'h014
`define HWL_OFF_SPTR 12'h018
`define HWL_OFF_TOPH 12'h01C
`define HWL_OFF_TOPL 12'h020
`define HWL_OFF_FADR 12'h024
`define HWL_OFF_PCNX 12'h028
`define HWL_OFF_PCUR 12'h02C

// control register fields
`define HWL_CTRL_START 0
`define HWL_CTRL_SHORT 1
`define HWL_CTRL_FETCH 2

// status word fields
`define HWL_SR_LOOP 15

// reset values and the short-count mask
`define HWL_RST_WORD 16'h0000
`define HWL_RST_SP 4'h0
`define HWL_SHORT_MASK 16'h0FFF

// stack depth, address width of stack pointer
`define HWL_STACK_DEPTH 16
`define HWL_SP_W 4

// bus responses
`define HWL_RESP_OKAY 2'b00
`define HWL_RESP_SLVERR 2'b10

`endif

// [rtl/hwloop_pkg.sv]
// hwloop_pkg.sv: types of the zero-overhead loop unit
// assumes hwloop_consts.svh for widths
`include "hwloop_consts.svh"

package hwloop_pkg;

  // loop start sequence states
  typedef enum logic [1:0] {
    HWL_IDLE,
    HWL_PUSH1,
    HWL_PUSH2,
    HWL_ARM
  } hwloop_seq_e;

  // one stack entry: high and low word
  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
  } hwloop_entry_s;

  // one stack operation request
  typedef struct packed {
    logic push;
    logic pop;
    hwloop_entry_s data;
  } hwloop_stkop_s;

  // word type
  typedef logic [15:0] hwloop_word_t;

endpackage : hwloop_pkg

// [rtl/hwloop_stack.sv]
// hwloop_stack.sv: system stack for loop state, pointer plus entry array
// assumes at most one push or pop each cycle; over/underflow wraps
`include "hwloop_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module hwloop_stack
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // operation
  input wire hwloop_pkg::hwloop_stkop_s op,
  // state out
  output logic [`HWL_SP_W-1:0] stackPtr,
  output hwloop_pkg::hwloop_entry_s top,
  output hwloop_pkg::hwloop_entry_s below
);
  import hwloop_pkg::*;

  // entry array, index 0 unused as empty position
  hwloop_entry_s mem_r [`HWL_STACK_DEPTH];
  logic [`HWL_SP_W-1:0] sp_r;

  // pointer moves up on push, down on pop
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sp_r <= `HWL_RST_SP;
    else if (op.push)
      sp_r <= sp_r + 4'h1;
    else if (op.pop)
      sp_r <= sp_r - 4'h1;
  end

  // push writes the slot above the pointer
  always_ff @(posedge clk)
  begin
    if (op.push)
      mem_r[sp_r + 4'h1] <= op.data;
  end

  assign stackPtr = sp_r;
  assign top = mem_r[sp_r];
  assign below = mem_r[sp_r - 4'h1];

endmodule // hwloop_stack

`default_nettype wire

// [rtl/hwloop_axil.sv]
// hwloop_axil.sv: AXI4-Lite slave front end, one write and one read at a time
// assumes the owner decodes addresses and supplies read data combinationally
`include "hwloop_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module hwloop_axil
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // write channels
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output logic wrStb,
  output logic [11:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrOk,
  output logic [11:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdOk
);

  logic haveAw_r;
  logic haveW_r;

  // capture address and data in either order
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      haveAw_r <= 1'b0;
      haveW_r <= 1'b0;
      wrAddr <= 12'h000;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        haveAw_r <= 1'b1;
        wrAddr <= awaddr;
      end
      if (wvalid && wready)
      begin
        haveW_r <= 1'b1;
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (wrStb)
      begin
        haveAw_r <= 1'b0;
        haveW_r <= 1'b0;
      end
    end
  end

  assign awready = !haveAw_r && !bvalid;
  assign wready = !haveW_r && !bvalid;
  assign wrStb = haveAw_r && haveW_r && !bvalid;

  // write response one cycle after both halves are held
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bvalid <= 1'b0;
      bresp <= `HWL_RESP_OKAY;
    end
    else if (wrStb)
    begin
      bvalid <= 1'b1;
      bresp <= wrOk ? `HWL_RESP_OKAY : `HWL_RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // read answer one cycle after the address is taken
  assign arready = !rvalid;
  assign rdAddr = araddr;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `HWL_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= rdOk ? rdData : 32'h0000_0000;
      rresp <= rdOk ? `HWL_RESP_OKAY : `HWL_RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

endmodule // hwloop_axil

`default_nettype wire

// [sim/hwl_ctrl_props.sv]
// hwl_ctrl_props.sv: register bus timing and response checks for the loop unit
// assumes binding to hwloop_ctrl, watching only its bus ports
`include "hwloop_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module hwl_ctrl_props
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // write side
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read side
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // address and data taken in one edge
  wire logic wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic rdTake = s_axi_arvalid && s_axi_arready;
  // aligned and inside the map
  wire logic rdMap = (s_axi_araddr <= `HWL_OFF_PCUR) && (s_axi_araddr[1:0] == 2'b00);
  // read-only places
  wire logic wrRo = s_axi_awaddr inside {12'h00C, 12'h010, 12'h018, 12'h01C, 12'h020, 12'h02C};
  ////////////////////////////////////////////////////////////////////////////
  property p_wlat; wrTake |-> ##[1:2] s_axi_bvalid; endproperty
  a_wlat: assert property (p_wlat) else $error("write answer late");
  property p_rlat; rdTake |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rerr;
    rdTake && !rdMap |=> s_axi_rresp == `HWL_RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_rerr: assert property (p_rerr) else $error("unmapped read not refused");
  property p_rok; rdTake && rdMap |=> s_axi_rresp == `HWL_RESP_OKAY; endproperty
  a_rok: assert property (p_rok) else $error("mapped read refused");
  property p_roerr;
    wrTake && wrRo |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == `HWL_RESP_SLVERR);
  endproperty
  a_roerr: assert property (p_roerr) else $error("read-only write not refused");
  property p_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read half not zero");
  property p_bone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bone: assert property (p_bone) else $error("write answer repeated");
  property p_rone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rone: assert property (p_rone) else $error("read answer repeated");
  // main scenarios
  c_rerr: cover property (rdTake && !rdMap);
  c_roerr: cover property (wrTake && wrRo);
  c_rok: cover property (rdTake && rdMap);
endmodule // hwl_ctrl_props

bind hwloop_ctrl hwl_ctrl_props chk_u (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);
`default_nettype wire

// [sim/hwl_fetch_bfm.sv]
// hwl_fetch_bfm.sv: fetch sequencer model, speaks to the loop unit as bus master
// assumes one task call at a time; released payloads show inverted values
`timescale 1ns/1ps
`default_nettype none

module hwl_fetch_bfm
(
  // clock
  input wire logic clk,
  // write channels
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  output logic rready
);
  int errs; // waits that ran out
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    errs = 0;
  end
  // one write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic pa, pw, done;
    int n;
    {pa, pw, done} = 3'b110;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 50)
    begin
      @(posedge clk);
      n++;
      if (!pa && !pw && bvalid)
      begin
        done = 1'b1;
        bready <= 1'b0;
      end
      if (pa && awready)
      begin
        pa = 1'b0;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (pw && wready)
      begin
        pw = 1'b0;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    if (!done)
      errs++;
  endtask
  // one read: address held until taken, data taken with rvalid
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic pa, done;
    int n;
    {pa, done} = 2'b10;
    n = 0;
    d = '0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 50)
    begin
      @(posedge clk);
      n++;
      if (!pa && rvalid)
      begin
        done = 1'b1;
        d = rdata;
        rready <= 1'b0;
      end
      if (pa && arready)
      begin
        pa = 1'b0;
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end
    if (!done)
      errs++;
  endtask
endmodule // hwl_fetch_bfm
`default_nettype wire

// [sim/tb_hardware_loop_controller.sv]
// tb_hardware_loop_controller.sv: self-checking bench for the loop unit
// assumes the fetch model as bus master; expectations queued, checked on answers
`include "hwloop_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define HWL_CHK(nm, e, g) begin testsRun++; if ((e) !== (g)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module tb_hardware_loop_controller;
  typedef struct {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} hwl_exp_s;
  localparam logic [1:0] respOk = `HWL_RESP_OKAY;
  localparam logic [1:0] respErr = `HWL_RESP_SLVERR;
  logic clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdLast;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] cnt, pc, lend;
  int miscompares, testsRun, seed, k;
  hwl_exp_s expQ[$];
  hwl_exp_s monE;
  hwloop_ctrl dut_u (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  hwl_fetch_bfm bfm_u (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rvalid(rvalid), .rready(rready));
  ////////////////////////////////////////////////////////////////////////////
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // verdict and end of run
  task automatic finalReport();
    miscompares = miscompares + bfm_u.errs;
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // answer watcher: oldest note against each response
  always @(posedge clk)
  begin
    if (bfm_u.errs != 0)
      finalReport();
    if ((bvalid && bready) || (rvalid && rready))
    begin
      if (expQ.size() == 0)
        `HWL_CHK("queue", 1'b1, 1'b0)
      else
      begin
        monE = expQ.pop_front();
        `HWL_CHK("resp", monE.resp, (rvalid ? rresp : bresp))
        if (rvalid)
          `HWL_CHK("rdata", monE.data & monE.mask, rdata & monE.mask)
      end
    end
  end
  // hang guard
  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    finalReport();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrx(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    expQ.push_back('{r, 32'h0000_0000, 32'h0000_0000});
    bfm_u.wr(a, d);
  endtask
  task automatic rdx(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] r);
    expQ.push_back('{r, e, m});
    bfm_u.rd(a, rdLast);
  endtask
  task automatic chk(input logic [11:0] a, input logic [15:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
    rdx(a, {16'h0000, e}, m, respOk);
  endtask
  // present a fetch address, check the next address handed back
  task automatic fetch(input logic [15:0] a, input logic [15:0] nx);
    wrx(`HWL_OFF_FADR, {16'h0000, a}, respOk);
    chk(`HWL_OFF_PCUR, nx);
  endtask
  // start a loop and wait, bounded, until the start sequence is over
  task automatic startLoop(input logic [15:0] c, input logic [15:0] ex, input logic [15:0] p,
                           input logic sh);
    int i;
    wrx(`HWL_OFF_ITER, {16'h0000, c}, respOk);
    wrx(`HWL_OFF_ENDX, {16'h0000, ex}, respOk);
    wrx(`HWL_OFF_PCNX, {16'h0000, p}, respOk);
    wrx(`HWL_OFF_CTRL, {30'h0000_0000, sh, 1'b1}, respOk);
    for (i = 0; i < 20; i++)
    begin
      rdx(`HWL_OFF_CTRL, 32'h0000_0000, 32'h0000_0000, respOk);
      if (rdLast[0] === 1'b0)
        break;
    end
    if (i == 20)
    begin
      miscompares++;
      finalReport();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {miscompares, testsRun} = '0;
    seed = 34;
    rstn = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    chk(`HWL_OFF_STAT, 16'h0000, 32'h0000_8000);
    chk(`HWL_OFF_SPTR, 16'h0000);
    rdx(12'h040, 32'h0000_0000, 32'hFFFF_FFFF, respErr);
    wrx(`HWL_OFF_LCNT, 32'h0000_1111, respErr);
    chk(`HWL_OFF_LCNT, 16'h0000);
    // random loop: count 2..5, body near a random top
    cnt = 16'(2 + ($random(seed) & 3));
    pc = 16'(16'h0100 + ($random(seed) & 16'h00F0));
    lend = 16'(pc + 16'h0007 + ($random(seed) & 7));
    wrx(`HWL_OFF_STAT, 32'h0000_1234, respOk);
    startLoop(cnt, lend + 16'h0001, pc, 1'b0);
    chk(`HWL_OFF_SPTR, 16'h0002);
    chk(`HWL_OFF_TOPH, pc);
    chk(`HWL_OFF_TOPL, 16'h1234);
    chk(`HWL_OFF_LCNT, cnt);
    chk(`HWL_OFF_LEND, lend);
    chk(`HWL_OFF_STAT, 16'h9234);
    wrx(`HWL_OFF_STAT, 32'h0000_0055, respOk);
    fetch(lend ^ 16'h8000, (lend ^ 16'h8000) + 16'h0001);
    fetch(lend ^ 16'h0001, (lend ^ 16'h0001) + 16'h0001);
    for (k = 1; k < cnt; k++)
    begin
      fetch(pc, pc + 16'h0001);
      fetch(lend, pc);
      chk(`HWL_OFF_LCNT, cnt - 16'(k));
      chk(`HWL_OFF_SPTR, 16'h0002);
    end
    fetch(lend, lend + 16'h0001);
    chk(`HWL_OFF_STAT, 16'h0055);
    chk(`HWL_OFF_SPTR, 16'h0000);
    chk(`HWL_OFF_LEND, 16'h0000);
    chk(`HWL_OFF_LCNT, 16'h0000);
    // zero count, then a nested short-count loop inside it
    startLoop(16'h0000, 16'h0300, 16'h0280, 1'b0);
    fetch(16'h02FF, 16'h0280);
    chk(`HWL_OFF_LCNT, 16'hFFFF);
    startLoop(16'hF001, 16'h02A0, 16'h0290, 1'b1); // inner end distinct from outer
    chk(`HWL_OFF_LCNT, 16'h0001);
    chk(`HWL_OFF_SPTR, 16'h0004);
    fetch(16'h029F, 16'h02A0);
    chk(`HWL_OFF_LCNT, 16'hFFFF);
    chk(`HWL_OFF_LEND, 16'h02FF);
    chk(`HWL_OFF_SPTR, 16'h0002);
    chk(`HWL_OFF_STAT, 16'h8000, 32'h0000_8000);
    // reset while the outer loop still runs
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    chk(`HWL_OFF_STAT, 16'h0000, 32'h0000_8000);
    chk(`HWL_OFF_SPTR, 16'h0000);
    finalReport();
  end
endmodule // tb_hardware_loop_controller
`default_nettype wire
